// ---- core/fmdc_decode.sv ----
// Purpose: opcode decode for the float divide, extended multiply and compare forms
// Assumes: instruction word already fetched; purely combinational
// Notes: based forms carry only a 2-bit base field, so bases outside 12-15 cannot occur
`timescale 1ns/100ps
module fmdc_decode (
  // instruction word
  input wire logic [15:0] instr_in,
  // decoded operation
  output fmdc_pkg::fmdc_dec_t dec_out
);
  function automatic fmdc_pkg::fmdc_dec_t mk(input fmdc_pkg::fmdc_op_t op, input logic ext,
    input logic [11:0] cyc, input logic [1:0] fch, input logic [1:0] opn, input logic [3:0] d);
    return {op, ext, cyc, fch, opn, d, 4'h0, 1'b1};
  endfunction

  // table of supported forms; anything else is flagged illegal
  always_comb
  begin
    case (instr_in[15:8])
      fmdc_pkg::OPC_DIV_MEM: dec_out = mk(fmdc_pkg::FMDC_OP_DIV, 1'b0, fmdc_pkg::CYC_DIV_MEM,
        fmdc_pkg::BUS_TWO, fmdc_pkg::BUS_TWO, instr_in[7:4]);
      fmdc_pkg::OPC_DIV_REG: dec_out = mk(fmdc_pkg::FMDC_OP_DIV, 1'b0, fmdc_pkg::CYC_DIV_REG,
        fmdc_pkg::BUS_ONE, fmdc_pkg::BUS_NONE, instr_in[7:4]);
      fmdc_pkg::OPC_XDIV_MEM: dec_out = mk(fmdc_pkg::FMDC_OP_DIV, 1'b1, fmdc_pkg::CYC_XDIV_MEM,
        fmdc_pkg::BUS_TWO, fmdc_pkg::BUS_THREE, instr_in[7:4]);
      fmdc_pkg::OPC_XDIV_REG: dec_out = mk(fmdc_pkg::FMDC_OP_DIV, 1'b1, fmdc_pkg::CYC_XDIV_REG,
        fmdc_pkg::BUS_ONE, fmdc_pkg::BUS_NONE, instr_in[7:4]);
      fmdc_pkg::OPC_XMUL_MEM: dec_out = mk(fmdc_pkg::FMDC_OP_MUL, 1'b1, fmdc_pkg::CYC_XMUL_MEM,
        fmdc_pkg::BUS_TWO, fmdc_pkg::BUS_THREE, instr_in[7:4]);
      fmdc_pkg::OPC_XMUL_REG: dec_out = mk(fmdc_pkg::FMDC_OP_MUL, 1'b1, fmdc_pkg::CYC_XMUL_REG,
        fmdc_pkg::BUS_ONE, fmdc_pkg::BUS_NONE, instr_in[7:4]);
      fmdc_pkg::OPC_CMP_MEM: dec_out = mk(fmdc_pkg::FMDC_OP_CMP, 1'b0, fmdc_pkg::CYC_CMP_MEM,
        fmdc_pkg::BUS_TWO, fmdc_pkg::BUS_TWO, instr_in[7:4]);
      fmdc_pkg::OPC_CMP_REG: dec_out = mk(fmdc_pkg::FMDC_OP_CMP, 1'b0, fmdc_pkg::CYC_CMP_REG,
        fmdc_pkg::BUS_ONE, fmdc_pkg::BUS_NONE, instr_in[7:4]);
      default:
      begin
        dec_out = '0;
        // based forms: accumulator is register zero, base is field plus twelve
        if (instr_in[15:10] == fmdc_pkg::OPC_DIV_BASED || (instr_in[15:10] ==
          fmdc_pkg::OPC_DIV_BASEDX && instr_in[7:4] == fmdc_pkg::OPC_BASEDX_EXT))
        begin
          dec_out = mk(fmdc_pkg::FMDC_OP_DIV, 1'b0, fmdc_pkg::CYC_DIV_BASED,
            fmdc_pkg::BUS_ONE, fmdc_pkg::BUS_TWO, 4'h0);
          dec_out.base = {2'b00, instr_in[9:8]} + fmdc_pkg::BASE_OFS;
        end
      end
    endcase
  end
endmodule

// ---- core/fmdc_divider.sv ----
// Purpose: restoring divider of two fraction magnitudes
// Assumes: divisor nonzero; caller screens zero divisors first
// Notes: quotient is a/b scaled by 2**(W-1), two integer bits above the fraction
`timescale 1ns/100ps
module fmdc_divider #(
  parameter int W = 40
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // request
  input wire logic start_in,
  input wire logic [W-1:0] dividend_in,
  input wire logic [W-1:0] divisor_in,
  // answer
  output logic [W:0] quotient_out,
  output logic done_out
);
  logic [W+1:0] rem;
  logic [W:0] dvs;
  logic [6:0] step;
  logic [W+1:0] diff;

  assign diff = rem - {1'b0, dvs};

  // one quotient bit per clock; divisor doubled so the first bit weighs two
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rem <= '0;
      dvs <= '0;
      step <= '0;
      quotient_out <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in)
      begin
        rem <= {2'b00, dividend_in};
        dvs <= {divisor_in, 1'b0};
        step <= 7'(W + 1);
        quotient_out <= '0;
      end
      else if (step != 7'h00)
      begin
        if (!diff[W+1])
          rem <= {diff[W:0], 1'b0};
        else
          rem <= {rem[W:0], 1'b0};
        quotient_out <= {quotient_out[W-1:0], !diff[W+1]};
        step <= step - 7'h01;
        done_out <= (step == 7'h01);
      end
    end
  end
endmodule

// ---- core/fmdc_pkg.sv ----
// Purpose: shared constants, carriers and helpers of the float multiply/divide/compare unit
// Assumes: 16-bit register words; fractions held 40 bits wide, single uses the top 24
// Notes: words run from the destination register (msw) through the next two
// Functional notes
// - multiply exponent overflow saturates by operand signs
// - multiply exponent underflow zeroes result and stops
// - product is signed multiply, shifted left once
// - minus-one product becomes half, exponent plus one
// - recheck overflow after adjust, saturate by sign
// - normalise, recheck underflow, store exponent and fraction
// - extended result sets zero, negative, positive code
// - single divide uses pair and operand, writes pair
// - divide flags overflow or underflow at any step
// - divide underflow writes a zero quotient
// - zero divisor is overflow with signed saturation
// - divide exponent is difference, zero for zero dividend
// - divide saturation picks fraction from operand signs
// - quotient at least one shifts right, exponent plus one
// - final overflow saturates by quotient sign
// - extended divide uses triple with same checks
// - single divide opcodes and their cycle counts
// - based divide uses bases 12-15, accumulator zero
// - extended divide opcodes and their cycle counts
// - compare sets code only, registers untouched
// - compare never raises overflow
// - normalising shifts lengthen execution time
// - single results set the same condition code
package fmdc_pkg;
  localparam int FRAC_W = 40;
  localparam int CYC_W = 12;
  localparam int FLAG_OVF_BIT = 3;
  localparam int FLAG_UNF_BIT = 6;
  // exponent limits held 10 bits wide so sums cannot wrap
  localparam logic signed [9:0] EXP_MAX = 10'sh07F;
  localparam logic signed [9:0] EXP_MIN = 10'sh380;
  localparam logic [39:0] FRAC_POS_MAX = 40'h7FFFFFFFFF;
  localparam logic [39:0] FRAC_NEG_MAX = 40'h8000000000;
  localparam logic [39:0] FRAC_HALF = 40'h4000000000;
  localparam logic [39:0] SGL_MASK = 40'hFFFFFF0000;
  localparam logic [40:0] QUOT_ONE = 41'h08000000000;
  localparam logic [3:0] CC_ZERO = 4'h2;
  localparam logic [3:0] CC_NEG = 4'h1;
  localparam logic [3:0] CC_POS = 4'h4;
  localparam logic [7:0] OPC_DIV_MEM = 8'hD8;
  localparam logic [7:0] OPC_DIV_REG = 8'hD9;
  localparam logic [7:0] OPC_XDIV_MEM = 8'hDA;
  localparam logic [7:0] OPC_XDIV_REG = 8'hDB;
  localparam logic [7:0] OPC_XMUL_MEM = 8'hCA;
  localparam logic [7:0] OPC_XMUL_REG = 8'hCB;
  localparam logic [7:0] OPC_CMP_MEM = 8'hF8;
  localparam logic [7:0] OPC_CMP_REG = 8'hF9;
  localparam logic [5:0] OPC_DIV_BASED = 6'h0B;
  localparam logic [5:0] OPC_DIV_BASEDX = 6'h10;
  localparam logic [3:0] OPC_BASEDX_EXT = 4'hB;
  localparam logic [3:0] BASE_OFS = 4'hC;
  localparam logic [11:0] CYC_DIV_MEM = 12'h0F0;
  localparam logic [11:0] CYC_DIV_REG = 12'h0EA;
  localparam logic [11:0] CYC_DIV_BASED = 12'h0EF;
  localparam logic [11:0] CYC_XDIV_MEM = 12'h1E7;
  localparam logic [11:0] CYC_XDIV_REG = 12'h1E0;
  localparam logic [11:0] CYC_XMUL_MEM = 12'h102;
  localparam logic [11:0] CYC_XMUL_REG = 12'h0FB;
  localparam logic [11:0] CYC_CMP_MEM = 12'h03A;
  localparam logic [11:0] CYC_CMP_REG = 12'h034;
  localparam logic [1:0] BUS_NONE = 2'h0;
  localparam logic [1:0] BUS_ONE = 2'h1;
  localparam logic [1:0] BUS_TWO = 2'h2;
  localparam logic [1:0] BUS_THREE = 2'h3;

  typedef enum logic [1:0] {FMDC_OP_NONE = 2'b00, FMDC_OP_DIV = 2'b01,
    FMDC_OP_MUL = 2'b10, FMDC_OP_CMP = 2'b11} fmdc_op_t;
  typedef struct packed {logic [7:0] exp; logic [39:0] frac;} fmdc_fp_t;
  typedef struct packed {fmdc_op_t op; logic ext; logic [11:0] cycles; logic [1:0] fetch_cyc;
    logic [1:0] opnd_cyc; logic [3:0] dest; logic [3:0] base; logic legal;} fmdc_dec_t;

  function automatic logic signed [9:0] exp_sx(input logic [7:0] e);
    return {{2{e[7]}}, e};
  endfunction
  function automatic fmdc_fp_t unpack(input logic [47:0] w, input logic ext);
    return {w[23:16], w[47:24], ext ? w[15:0] : 16'h0000};
  endfunction
  function automatic logic [47:0] pack(input fmdc_fp_t f, input logic ext);
    return {f.frac[39:16], f.exp, ext ? f.frac[15:0] : 16'h0000};
  endfunction
  function automatic logic [3:0] cc_of(input fmdc_fp_t f, input logic ext);
    if (pack(f, ext) == 48'h000000000000)
      return CC_ZERO;
    return f.frac[39] ? CC_NEG : CC_POS;
  endfunction
  function automatic fmdc_fp_t sat(input logic neg);
    return {EXP_MAX[7:0], neg ? FRAC_NEG_MAX : FRAC_POS_MAX};
  endfunction
endpackage

// ---- core/fmdc_unit.sv ----
// Purpose: float divide, extended multiply and compare datapath with its sequencer
// Assumes: operands arrive as register words on the start cycle and stay out of our way
// Notes: done is held back to the published cycle count, plus one per normalising shift
`timescale 1ns/100ps
module fmdc_unit (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // instruction issue
  input wire logic start_in,
  input wire logic [15:0] instr_in,
  input wire logic [47:0] acc_words_in,
  input wire logic [47:0] opnd_words_in,
  // sequencer status
  output logic busy_out,
  output logic illegal_out,
  output logic done_out,
  // register file write-back
  output logic dest_we_out,
  output logic dest_ext_out,
  output logic [3:0] dest_reg_out,
  output logic [47:0] dest_words_out,
  // condition code and pending flags
  output logic cc_we_out,
  output logic [3:0] cc_out,
  output logic [15:0] flag_set_out,
  // decode information for the bus sequencer
  output logic [3:0] base_reg_out,
  output logic [1:0] fetch_cycles_out,
  output logic [1:0] operand_cycles_out
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_DIVW = 3'b010,
    S_OVCHK = 3'b011,
    S_NORM = 3'b100,
    S_WAIT = 3'b101
  } fmdc_state_t;

  fmdc_state_t state;
  fmdc_pkg::fmdc_dec_t dec_w;
  fmdc_pkg::fmdc_dec_t dec;
  fmdc_pkg::fmdc_fp_t acc_fp;
  fmdc_pkg::fmdc_fp_t opnd_fp;
  fmdc_pkg::fmdc_fp_t res;
  logic signed [9:0] n;
  logic signed [39:0] mp;
  logic pend_ovf;
  logic pend_unf;
  logic [11:0] cnt;
  logic [11:0] target;
  logic signed [79:0] prod;
  logic signed [39:0] prod_top;
  logic signed [9:0] n_sum;
  logic signed [9:0] n_diff;
  logic sign_diff;
  logic div_start;
  logic div_done;
  logic [40:0] div_q;
  logic [40:0] q_mag;
  logic q_inc;
  logic finish;
  logic norm_shift;

  // magnitude of a signed fraction; minus one fits since the result is unsigned
  function automatic logic [39:0] mag(input logic [39:0] f);
    return f[39] ? 40'(-f) : f;
  endfunction

  // signed compare after aligning the smaller exponent; a zero takes the other exponent
  function automatic logic [3:0] cmp_code(input fmdc_pkg::fmdc_fp_t x,
    input fmdc_pkg::fmdc_fp_t y);
    logic signed [9:0] ex;
    logic signed [9:0] ey;
    logic signed [39:0] fx;
    logic signed [39:0] fy;
    begin
      ex = (x.frac == '0) ? fmdc_pkg::exp_sx(y.exp) : fmdc_pkg::exp_sx(x.exp);
      ey = (y.frac == '0) ? ex : fmdc_pkg::exp_sx(y.exp);
      fx = x.frac;
      fy = y.frac;
      if (ex > ey)
        fy = fy >>> (ex - ey);
      else
        fx = fx >>> (ey - ex);
      if (fx == fy)
        return fmdc_pkg::CC_ZERO;
      return (fx < fy) ? fmdc_pkg::CC_NEG : fmdc_pkg::CC_POS;
    end
  endfunction

  fmdc_decode u_decode (
    .instr_in(instr_in),
    .dec_out(dec_w)
  );

  fmdc_divider #(
    .W(fmdc_pkg::FRAC_W)
  ) u_divider (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .start_in(div_start),
    .dividend_in(mag(acc_fp.frac)),
    .divisor_in(mag(opnd_fp.frac)),
    .quotient_out(div_q),
    .done_out(div_done)
  );

  // exponent sum and difference, product and its top bits
  assign prod = $signed(acc_fp.frac) * $signed(opnd_fp.frac);
  assign prod_top = prod[78:39];
  assign n_sum = fmdc_pkg::exp_sx(acc_fp.exp) + fmdc_pkg::exp_sx(opnd_fp.exp);
  assign n_diff = (acc_fp.frac == '0) ? 10'sh000 :
    fmdc_pkg::exp_sx(acc_fp.exp) - fmdc_pkg::exp_sx(opnd_fp.exp);
  assign sign_diff = acc_fp.frac[39] ^ opnd_fp.frac[39];
  assign finish = (state == S_WAIT) && (cnt >= target);
  assign norm_shift = (state == S_NORM) && (mp != '0) && (mp[39] == mp[38]);

  // quotient of one or more comes back into range; clamp covers unnormalised input
  always_comb
  begin
    q_inc = (div_q >= fmdc_pkg::QUOT_ONE);
    q_mag = q_inc ? (div_q >> 1) : div_q;
    if (q_mag[40:39] != 2'b00)
      q_mag = {1'b0, fmdc_pkg::FRAC_POS_MAX};
  end

  // operation sequencer and working datapath
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= S_IDLE;
      dec <= '0;
      acc_fp <= '0;
      opnd_fp <= '0;
      res <= '0;
      n <= '0;
      mp <= '0;
      pend_ovf <= 1'b0;
      pend_unf <= 1'b0;
      div_start <= 1'b0;
    end
    else
    begin
      div_start <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start_in && dec_w.legal)
          begin
            dec <= dec_w;
            acc_fp <= fmdc_pkg::unpack(acc_words_in, dec_w.ext);
            opnd_fp <= fmdc_pkg::unpack(opnd_words_in, dec_w.ext);
            pend_ovf <= 1'b0;
            pend_unf <= 1'b0;
            state <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          case (dec.op)
            fmdc_pkg::FMDC_OP_MUL:
            begin
              if (n_sum > fmdc_pkg::EXP_MAX)
              begin
                res <= fmdc_pkg::sat(sign_diff);
                pend_ovf <= 1'b1;
                state <= S_WAIT;
              end
              else if (n_sum < fmdc_pkg::EXP_MIN)
              begin
                res <= '0;
                pend_unf <= 1'b1;
                state <= S_WAIT;
              end
              else if (prod_top == $signed(fmdc_pkg::FRAC_NEG_MAX))
              begin
                mp <= fmdc_pkg::FRAC_HALF;
                n <= n_sum + 10'sh001;
                state <= S_OVCHK;
              end
              else
              begin
                mp <= prod_top;
                n <= n_sum;
                state <= S_OVCHK;
              end
            end
            fmdc_pkg::FMDC_OP_DIV:
            begin
              // zero divisor is screened here so the divider never sees it
              if (n_diff > fmdc_pkg::EXP_MAX || opnd_fp.frac == '0)
              begin
                res <= fmdc_pkg::sat(sign_diff);
                pend_ovf <= 1'b1;
                state <= S_WAIT;
              end
              else if (n_diff < fmdc_pkg::EXP_MIN)
              begin
                res <= '0;
                pend_unf <= 1'b1;
                state <= S_WAIT;
              end
              else
              begin
                n <= n_diff;
                div_start <= 1'b1;
                state <= S_DIVW;
              end
            end
            default:
            begin
              // compare: code only, no write, no flag
              state <= S_WAIT;
            end
          endcase
        end
        S_DIVW:
        begin
          if (div_done)
          begin
            mp <= sign_diff ? -$signed(q_mag[39:0]) : $signed(q_mag[39:0]);
            n <= n + (q_inc ? 10'sh001 : 10'sh000);
            state <= S_OVCHK;
          end
        end
        S_OVCHK:
        begin
          if (n > fmdc_pkg::EXP_MAX)
          begin
            res <= fmdc_pkg::sat(mp[39]);
            pend_ovf <= 1'b1;
            state <= S_WAIT;
          end
          else if (dec.op == fmdc_pkg::FMDC_OP_MUL)
            state <= S_NORM;
          else
          begin
            res <= {n[7:0], mp};
            state <= S_WAIT;
          end
        end
        S_NORM:
        begin
          if (mp == '0)
          begin
            res <= '0;
            state <= S_WAIT;
          end
          else if (mp[39] == mp[38])
          begin
            mp <= mp <<< 1;
            n <= n - 10'sh001;
          end
          else if (n < fmdc_pkg::EXP_MIN)
          begin
            res <= '0;
            pend_unf <= 1'b1;
            state <= S_WAIT;
          end
          else
          begin
            res <= {n[7:0], mp};
            state <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (finish)
            state <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // execution time: published count, stretched by each normalising shift
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt <= '0;
      target <= '0;
    end
    else if (state == S_IDLE)
    begin
      cnt <= 12'h001;
      target <= dec_w.cycles;
    end
    else
    begin
      cnt <= cnt + 12'h001;
      if (norm_shift)
        target <= target + 12'h001;
    end
  end

  // registered outputs; results appear only once the count is spent
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      illegal_out <= 1'b0;
      done_out <= 1'b0;
      dest_we_out <= 1'b0;
      dest_ext_out <= 1'b0;
      dest_reg_out <= '0;
      dest_words_out <= '0;
      cc_we_out <= 1'b0;
      cc_out <= '0;
      flag_set_out <= '0;
      base_reg_out <= '0;
      fetch_cycles_out <= '0;
      operand_cycles_out <= '0;
    end
    else
    begin
      illegal_out <= 1'b0;
      done_out <= 1'b0;
      dest_we_out <= 1'b0;
      cc_we_out <= 1'b0;
      flag_set_out <= '0;
      if (state == S_IDLE && start_in)
      begin
        illegal_out <= !dec_w.legal;
        busy_out <= dec_w.legal;
        dest_ext_out <= dec_w.ext;
        dest_reg_out <= dec_w.dest;
        base_reg_out <= dec_w.base;
        fetch_cycles_out <= dec_w.fetch_cyc;
        operand_cycles_out <= dec_w.opnd_cyc;
      end
      if (finish)
      begin
        busy_out <= 1'b0;
        done_out <= 1'b1;
        cc_we_out <= 1'b1;
        // compare leaves the pair alone and never flags
        dest_we_out <= (dec.op != fmdc_pkg::FMDC_OP_CMP);
        dest_words_out <= fmdc_pkg::pack(res, dec.ext);
        if (dec.op == fmdc_pkg::FMDC_OP_CMP)
          cc_out <= cmp_code(acc_fp, opnd_fp);
        else
          cc_out <= fmdc_pkg::cc_of(res, dec.ext);
        flag_set_out[fmdc_pkg::FLAG_OVF_BIT] <= pend_ovf;
        flag_set_out[fmdc_pkg::FLAG_UNF_BIT] <= pend_unf;
      end
    end
  end
endmodule

// ---- tb/fmdc_issue_model.sv ----
// Purpose: issue side of the processor: holds the instruction and operand words until the unit takes them
// Assumes: one request pulse from the bench per instruction
// Notes: words are scrambled once taken, since the unit samples them only at start
`timescale 1ns/100ps
module fmdc_issue_model (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // request from the bench
  input wire logic req_in,
  input wire logic [15:0] instr_in,
  input wire logic [47:0] acc_in,
  input wire logic [47:0] opnd_in,
  // unit status
  input wire logic busy_in,
  input wire logic done_in,
  // issue lines
  output logic start_out,
  output logic [15:0] instr_out,
  output logic [47:0] acc_out,
  output logic [47:0] opnd_out
);
  // hold the request until taken, then drop it and invert the stale words
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
    begin
      start_out <= 1'b0;
      instr_out <= 16'h0000;
      acc_out <= 48'h000000000000;
      opnd_out <= 48'h000000000000;
    end
    else if (req_in)
    begin
      start_out <= 1'b1;
      instr_out <= instr_in;
      acc_out <= acc_in;
      opnd_out <= opnd_in;
    end
    else if (start_out && (!busy_in || done_in))
    begin
      start_out <= 1'b0;
      instr_out <= ~instr_out;
      acc_out <= ~acc_out;
      opnd_out <= ~opnd_out;
    end
endmodule

// ---- tb/fmdc_unit_asserts.sv ----
// Purpose: port-level checks of the float divide, multiply and compare unit
// Assumes: single clock domain, reset active high
// Notes: compare is recognised as a done cycle without a register write
`timescale 1ns/100ps
module fmdc_unit_asserts (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // issue
  input wire logic start_in,
  input wire logic [15:0] instr_in,
  // status and results
  input wire logic busy_out,
  input wire logic illegal_out,
  input wire logic done_out,
  input wire logic dest_we_out,
  input wire logic dest_ext_out,
  input wire logic cc_we_out,
  input wire logic [3:0] cc_out,
  input wire logic [15:0] flag_set_out,
  input wire logic [47:0] dest_words_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // a start counts only while idle or in the done cycle
  logic take;
  assign take = start_in && (!busy_out || done_out);
  chk_pulse_with_done: assert property (
    (dest_we_out || cc_we_out || flag_set_out != 16'h0000) |-> done_out)
    else $error("write or flag outside done");
  chk_cc_from_result: assert property (done_out && dest_we_out |-> cc_we_out &&
    cc_out == (dest_words_out == 48'h0 ? 4'h2 : (dest_words_out[47] ? 4'h1 : 4'h4)))
    else $error("code does not match result");
  // single results leave the third word zero, so saturation shows only in the top two
  chk_ovf_saturates: assert property (done_out && dest_we_out && flag_set_out[3] |->
    dest_words_out[23:16] == 8'h7F && dest_words_out[46:24] == {23{~dest_words_out[47]}}
    && dest_words_out[15:0] == (dest_ext_out ? {16{~dest_words_out[47]}} : 16'h0000))
    else $error("overflow not saturated");
  chk_unf_zero: assert property (done_out && flag_set_out[6] |->
    dest_words_out == 48'h0 && !flag_set_out[3]) else $error("underflow result not zero");
  chk_cmp_quiet: assert property (done_out && !dest_we_out |->
    flag_set_out == 16'h0000 && cc_we_out) else $error("compare raised a flag");
  chk_flag_bits: assert property ((flag_set_out & 16'hFFB7) == 16'h0000)
    else $error("unexpected pending flag bit");
  chk_div_time: assert property (take && instr_in[15:8] == 8'hD9 |->
    ##234 !done_out ##1 done_out && dest_we_out) else $error("register divide time wrong");
  chk_cmp_time: assert property (take && instr_in[15:8] == 8'hF9 |->
    ##52 !done_out ##1 done_out && !dest_we_out) else $error("register compare time wrong");
  chk_illegal_flag: assert property (take && instr_in[15:8] == 8'h00 |=>
    illegal_out && !busy_out) else $error("unknown opcode not refused");
endmodule
bind fmdc_unit fmdc_unit_asserts u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .start_in(start_in), .instr_in(instr_in), .busy_out(busy_out), .illegal_out(illegal_out),
  .done_out(done_out), .dest_we_out(dest_we_out), .dest_ext_out(dest_ext_out),
  .cc_we_out(cc_we_out), .cc_out(cc_out), .flag_set_out(flag_set_out),
  .dest_words_out(dest_words_out));

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the float divide, multiply and compare unit
// Assumes: expected results worked out by hand from the operation rules
// Notes: early exits keep the published time; multiply adds a cycle per shift
`timescale 1ns/100ps
module testbench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req = 1'b0;
  logic [15:0] r_instr = 16'h0000;
  logic [47:0] r_acc = 48'h000000000000;
  logic [47:0] r_opnd = 48'h000000000000;
  logic start, busy, illegal, done, we, ext, ccwe;
  logic [15:0] instr, flags;
  logic [47:0] acc, opnd, words;
  logic [3:0] dreg, cc, base;
  logic [1:0] fcyc, oc;
  int comparisons = 0;
  int miscompares = 0;
  localparam logic [47:0] ONE = 48'h400000010000;
  localparam logic [47:0] TWO = 48'h400000020000;

  fmdc_issue_model u_host (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
    .instr_in(r_instr), .acc_in(r_acc), .opnd_in(r_opnd), .busy_in(busy), .done_in(done),
    .start_out(start), .instr_out(instr), .acc_out(acc), .opnd_out(opnd));
  fmdc_unit u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start), .instr_in(instr),
    .acc_words_in(acc), .opnd_words_in(opnd), .busy_out(busy), .illegal_out(illegal),
    .done_out(done), .dest_we_out(we), .dest_ext_out(ext), .dest_reg_out(dreg),
    .dest_words_out(words), .cc_we_out(ccwe), .cc_out(cc), .flag_set_out(flags),
    .base_reg_out(base), .fetch_cycles_out(fcyc), .operand_cycles_out(oc));

  // 250 MHz
  always #2 mclk_in = ~mclk_in;

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // pulse a request, return at the edge where the unit takes it
  task automatic send(input logic [15:0] ins, input logic [47:0] a, input logic [47:0] o);
    int n;
    n = 0;
    r_instr <= ins;
    r_acc <= a;
    r_opnd <= o;
    req <= 1'b1;
    @(posedge mclk_in);
    req <= 1'b0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (!(start && (!busy || done)) && n < 8);
  endtask

  // info packs write flag, dest, base, fetch and operand bus cycles
  task automatic issue(input logic [15:0] ins, input logic [47:0] a, input logic [47:0] o,
    input logic [47:0] ew, input logic [3:0] ecc, input logic [15:0] epi,
    input logic [12:0] info, input int t);
    int n;
    send(ins, a, o);
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (!done && n < 600);
    check("cycles", 48'(n), 48'(t + 1));
    check("decode", {35'h0, we, dreg, base, fcyc, oc}, {35'h0, info});
    check("ext", {47'h0, ext}, {47'h0, ins[15:9] == 7'h6D || ins[15:9] == 7'h65});
    if (info[12])
      check("words", words, ew);
    check("cc", {43'h0, ccwe, cc}, {43'h0, 1'b1, ecc});
    check("flags", {32'h0, flags}, {32'h0, epi});
  endtask

  task automatic t_div();
    issue(16'hD935, TWO, ONE, TWO, 4'h4, 16'h0000, {1'b1, 4'h3, 4'h0, 4'h4}, 234);
    issue(16'hD812, TWO, 48'h0, 48'h7FFFFF7F0000, 4'h4, 16'h0008, {5'h11, 8'h0A}, 240);
    issue(16'hD812, 48'hC00000010000, 48'h0, 48'h8000007F0000, 4'h1, 16'h0008,
      {5'h11, 8'h0A}, 240);
  endtask

  // based forms: accumulator zero, base 13
  task automatic t_based();
    issue(16'h2D05, TWO, ONE, TWO, 4'h4, 16'h0000, {1'b1, 4'h0, 4'hD, 4'h6}, 239);
    issue(16'h41B3, TWO, ONE, TWO, 4'h4, 16'h0000, {1'b1, 4'h0, 4'hD, 4'h6}, 239);
  endtask

  task automatic t_xdiv();
    issue(16'hDA20, 48'h400000800000, ONE, 48'h0, 4'h2, 16'h0040, {5'h12, 8'h0B}, 487);
    issue(16'hDB47, 48'h4000007F0000, 48'hC00000FF0000, 48'h8000007F0000, 4'h1, 16'h0008,
      {5'h14, 8'h04}, 480);
  endtask

  // product 0.25 needs one normalising shift
  task automatic t_xmul();
    issue(16'hCB12, ONE, ONE, ONE, 4'h4, 16'h0000, {5'h11, 8'h04}, 252);
    issue(16'hCA12, 48'h800000000000, 48'h800000000000, ONE, 4'h4, 16'h0000,
      {5'h11, 8'h0B}, 258);
    issue(16'hCB12, 48'h4000007F0000, ONE, 48'h7FFFFF7FFFFF, 4'h4, 16'h0008,
      {5'h11, 8'h04}, 251);
    issue(16'hCB12, 48'h400000800000, 48'h400000FF0000, 48'h0, 4'h2, 16'h0040,
      {5'h11, 8'h04}, 251);
  endtask

  task automatic t_cmp();
    issue(16'hF934, ONE, TWO, 48'h0, 4'h1, 16'h0000, {5'h03, 8'h04}, 52);
    issue(16'hF834, TWO, TWO, 48'h0, 4'h2, 16'h0000, {5'h03, 8'h0A}, 58);
    issue(16'hF934, ONE, 48'hC00000010000, 48'h0, 4'h4, 16'h0000, {5'h03, 8'h04}, 52);
  endtask

  // unknown opcode gives only the refusal pulse
  task automatic t_illegal();
    send(16'h0012, ONE, ONE);
    @(posedge mclk_in);
    check("illegal", {47'h0, illegal}, 48'h1);
    check("busy", {47'h0, busy}, 48'h0);
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    t_div();
    t_based();
    t_xdiv();
    t_xmul();
    t_cmp();
    t_illegal();
    close_out();
  end

  // whole run is near 3400 cycles; allow about seven times that
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule
